// File: verilog/vpcm_params.svh
// Functional notes
// - Exchange 16-bit samples both directions
// - Drive continuous 2048 kHz codec master clock
// - Issue frame sync at 8 kHz
// - Frame spans exactly 256 master clocks
// - Port disabled until enable word bit0 set
// - Routing value 0x0011 passes samples both ways
// - Control port words forwarded to codec
// - Tone digit plays dual tone, then voice
`ifndef VPCM_PARAMS_SVH
`define VPCM_PARAMS_SVH

`define VPCM_CTRL_ADDR 16'h004B
`define VPCM_EN_ADDR 16'h0059
`define VPCM_EN_BIT 0
`define VPCM_EN_RESET 16'h0000
`define VPCM_ROUTE_RESET 16'h0000
`define VPCM_ROUTE_VOICE 16'h0011
`define VPCM_MCLK_HZ 2048000
`define VPCM_SAMPLE_HZ 8000
`define VPCM_FRAME_SLOTS 256
`define VPCM_SAMPLE_BITS 16
`define VPCM_SAMPLE_LAST_SLOT 8'h0F
`define VPCM_CTRL_LAST_SLOT 8'h1F
`define VPCM_LINK_CLK_HZ 83333333
`define VPCM_PHASE_BITS 24
`define VPCM_TONE_MS 100
`define VPCM_TONE_SAMPLES ((`VPCM_TONE_MS * `VPCM_SAMPLE_HZ) / 1000)

`endif

// File: verilog/vpcm_pkg.sv
package vpcm_pkg;
  typedef logic [15:0] vpcm_word_t;
  typedef logic [3:0] vpcm_digit_t;
  typedef enum logic [0:0] {VPCM_TONE_IDLE, VPCM_TONE_PLAY} vpcm_tone_state_t;
endpackage

// File: verilog/vpcm_tone_if.sv
`timescale 1ns/1ps
interface vpcm_tone_if;
  import vpcm_pkg::*;
  logic start;
  vpcm_digit_t digit;
  logic tick;
  vpcm_word_t sample;
  logic busy;
  modport ctl (output start, output digit, output tick, input sample, input busy);
  modport gen (input start, input digit, input tick, output sample, output busy);
endinterface

// File: verilog/vpcm_tone_gen.sv
`timescale 1ns/1ps
`include "vpcm_params.svh"
module vpcm_tone_gen #(
  parameter int TONE_SAMPLES = `VPCM_TONE_SAMPLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  vpcm_tone_if.gen tone
);
  import vpcm_pkg::*;

  localparam int FREQ_W = 16;

  function automatic logic [15:0] step_of(input int hz);
    step_of = 16'((hz * 65536) / `VPCM_SAMPLE_HZ);
  endfunction

  // Keypad rows and columns; E and F stand for star and hash
  function automatic logic [15:0] row_step(input vpcm_digit_t d);
    unique case (d)
      4'h1, 4'h2, 4'h3, 4'hA: row_step = step_of(697);
      4'h4, 4'h5, 4'h6, 4'hB: row_step = step_of(770);
      4'h7, 4'h8, 4'h9, 4'hC: row_step = step_of(852);
      default: row_step = step_of(941);
    endcase
  endfunction

  function automatic logic [15:0] col_step(input vpcm_digit_t d);
    unique case (d)
      4'h1, 4'h4, 4'h7, 4'hE: col_step = step_of(1209);
      4'h2, 4'h5, 4'h8, 4'h0: col_step = step_of(1336);
      4'h3, 4'h6, 4'h9, 4'hF: col_step = step_of(1477);
      default: col_step = step_of(1633);
    endcase
  endfunction

  // Quarter wave, each tone below quarter scale so the sum cannot overflow
  function automatic logic signed [15:0] sine(input logic [5:0] ph);
    logic [3:0] idx;
    logic [15:0] mag;
    idx = ph[4] ? ~ph[3:0] : ph[3:0];
    unique case (idx)
      4'h0: mag = 16'h0189;
      4'h1: mag = 16'h0496;
      4'h2: mag = 16'h0798;
      4'h3: mag = 16'h0A87;
      4'h4: mag = 16'h0D5D;
      4'h5: mag = 16'h1011;
      4'h6: mag = 16'h129E;
      4'h7: mag = 16'h14FD;
      4'h8: mag = 16'h1728;
      4'h9: mag = 16'h191A;
      4'hA: mag = 16'h1ACE;
      4'hB: mag = 16'h1C40;
      4'hC: mag = 16'h1D6C;
      4'hD: mag = 16'h1E50;
      4'hE: mag = 16'h1EEA;
      default: mag = 16'h1F36;
    endcase
    sine = ph[5] ? -$signed(mag) : $signed(mag);
  endfunction

  vpcm_tone_state_t state_reg;
  logic [FREQ_W-1:0] row_inc_reg, col_inc_reg, row_ph_reg, col_ph_reg;
  logic [15:0] left_reg;
  vpcm_word_t sample_reg;

  wire logic done = (left_reg == 16'h0001) && tone.tick;
  wire logic signed [15:0] mix = sine(row_ph_reg[15:10]) + sine(col_ph_reg[15:10]);

  assign tone.sample = sample_reg;
  assign tone.busy = (state_reg == VPCM_TONE_PLAY);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= VPCM_TONE_IDLE;
      row_inc_reg <= 16'h0000;
      col_inc_reg <= 16'h0000;
      row_ph_reg <= 16'h0000;
      col_ph_reg <= 16'h0000;
      left_reg <= 16'h0000;
      sample_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        VPCM_TONE_IDLE: if (tone.start) begin
          state_reg <= VPCM_TONE_PLAY;
          row_inc_reg <= row_step(tone.digit);
          col_inc_reg <= col_step(tone.digit);
          row_ph_reg <= 16'h0000;
          col_ph_reg <= 16'h0000;
          left_reg <= 16'(TONE_SAMPLES);
        end
        VPCM_TONE_PLAY: if (tone.tick) begin
          row_ph_reg <= row_ph_reg + row_inc_reg;
          col_ph_reg <= col_ph_reg + col_inc_reg;
          sample_reg <= mix;
          left_reg <= left_reg - 16'h0001;
          if (done) begin
            state_reg <= VPCM_TONE_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// File: verilog/vpcm_port.sv
`timescale 1ns/1ps
`include "vpcm_params.svh"
module vpcm_port #(
  parameter int LINK_CLK_HZ = `VPCM_LINK_CLK_HZ,
  parameter int TONE_SAMPLES = `VPCM_TONE_SAMPLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic mem_wr_i,
  input wire logic mem_rd_i,
  input wire vpcm_pkg::vpcm_word_t mem_addr_i,
  input wire vpcm_pkg::vpcm_word_t mem_wdata_i,
  output vpcm_pkg::vpcm_word_t mem_rdata_o,
  input wire logic route_wr_i,
  input wire vpcm_pkg::vpcm_word_t route_wdata_i,
  output vpcm_pkg::vpcm_word_t route_o,
  input wire logic tone_req_i,
  input wire vpcm_pkg::vpcm_digit_t tone_digit_i,
  output logic tone_busy_o,
  input wire logic line_valid_i,
  input wire vpcm_pkg::vpcm_word_t line_sample_i,
  output logic line_valid_o,
  output vpcm_pkg::vpcm_word_t line_sample_o,
  output logic ctrl_pending_o,
  output logic clock_output_o,
  output logic frame_sync_o,
  output logic serial_out_line_o,
  input wire logic serial_in_line_i
);
  import vpcm_pkg::*;

  localparam int PW = `VPCM_PHASE_BITS;
  localparam logic [PW-1:0] MCLK_INC = PW'((64'(`VPCM_MCLK_HZ) << PW) / 64'(LINK_CLK_HZ));

  // ---------------- System clock domain ----------------
  vpcm_word_t en_word_reg, route_reg, rdata_reg;
  vpcm_word_t line_hold_reg, ctrl_word_reg, out_sample_reg;
  logic ctrl_pend_reg, out_valid_reg;
  logic req_tgl_reg, busy_reg;
  vpcm_word_t req_tx_reg, req_ctrl_reg;
  logic req_ctrl_v_reg;
  logic ack_s1_reg, ack_s2_reg, ack_s3_reg;
  logic rx_s1_reg, rx_s2_reg, rx_s3_reg;
  logic en_sys_reg;

  vpcm_tone_if tone_bus ();

  wire logic wr_en = mem_wr_i && (mem_addr_i == `VPCM_EN_ADDR);
  wire logic wr_ctrl = mem_wr_i && (mem_addr_i == `VPCM_CTRL_ADDR);
  wire logic rd_en = mem_rd_i && (mem_addr_i == `VPCM_EN_ADDR);
  wire logic port_on = en_word_reg[`VPCM_EN_BIT];
  wire logic routed = port_on && (route_reg == `VPCM_ROUTE_VOICE);
  wire logic ack_seen = ack_s2_reg ^ ack_s3_reg;
  wire logic rx_seen = rx_s2_reg ^ rx_s3_reg;
  wire logic send_now = !busy_reg || ack_seen;
  wire vpcm_word_t to_codec = routed ? line_hold_reg : 16'h0000;

  // The link always owns these words; rx_word_lnk is read only once its rx toggle is seen
  vpcm_word_t rx_word_lnk;
  logic ack_tgl_lnk, rx_tgl_lnk;

  assign tone_bus.start = tone_req_i && routed && !tone_bus.busy;
  assign tone_bus.digit = tone_digit_i;
  assign tone_bus.tick = rx_seen;

  wire vpcm_word_t line_next = tone_bus.busy ? tone_bus.sample : rx_word_lnk;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_word_reg <= `VPCM_EN_RESET;
      route_reg <= `VPCM_ROUTE_RESET;
      rdata_reg <= 16'h0000;
    end else begin
      if (wr_en) begin
        en_word_reg <= mem_wdata_i;
      end
      if (route_wr_i) begin
        route_reg <= route_wdata_i;
      end
      rdata_reg <= rd_en ? en_word_reg : 16'h0000;
    end
  end

  // Control word queue of one; a newer write replaces an unsent one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_pend_reg <= 1'b0;
      ctrl_word_reg <= 16'h0000;
    end else if (wr_ctrl) begin
      ctrl_pend_reg <= 1'b1;
      ctrl_word_reg <= mem_wdata_i;
    end else if (send_now && port_on) begin
      ctrl_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      line_hold_reg <= 16'h0000;
    end else if (line_valid_i) begin
      line_hold_reg <= line_sample_i;
    end
  end

  // One request per frame: the link acknowledges when it loads a frame
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_tgl_reg <= 1'b0;
      busy_reg <= 1'b0;
      req_tx_reg <= 16'h0000;
      req_ctrl_reg <= 16'h0000;
      req_ctrl_v_reg <= 1'b0;
    end else if (send_now && port_on) begin
      req_tgl_reg <= ~req_tgl_reg;
      busy_reg <= 1'b1;
      req_tx_reg <= to_codec;
      req_ctrl_reg <= ctrl_word_reg;
      req_ctrl_v_reg <= ctrl_pend_reg && !wr_ctrl;
    end else if (ack_seen) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_s3_reg <= 1'b0;
      rx_s1_reg <= 1'b0;
      rx_s2_reg <= 1'b0;
      rx_s3_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ack_tgl_lnk;
      ack_s2_reg <= ack_s1_reg;
      ack_s3_reg <= ack_s2_reg;
      rx_s1_reg <= rx_tgl_lnk;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
    end
  end

  // Codec word is stable for a whole frame after its toggle is seen
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_valid_reg <= 1'b0;
      out_sample_reg <= 16'h0000;
    end else begin
      out_valid_reg <= rx_seen && (routed || tone_bus.busy);
      if (rx_seen) begin
        out_sample_reg <= routed ? line_next : 16'h0000;
      end
    end
  end

  vpcm_tone_gen #(
    .TONE_SAMPLES(TONE_SAMPLES)
  ) u_tone (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tone(tone_bus.gen)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_sys_reg <= 1'b0;
      tone_busy_o <= 1'b0;
    end else begin
      en_sys_reg <= port_on;
      tone_busy_o <= tone_bus.busy || tone_bus.start;
    end
  end

  assign mem_rdata_o = rdata_reg;
  assign route_o = route_reg;
  assign line_valid_o = out_valid_reg;
  assign line_sample_o = out_sample_reg;
  assign ctrl_pending_o = ctrl_pend_reg;

  // ---------------- Link clock domain ----------------
  logic lrst_s1_reg, lrst_reg;
  logic en_l1_reg, en_l2_reg;
  logic req_l1_reg, req_l2_reg, req_l3_reg;
  logic sdi_s1_reg, sdi_s2_reg;
  logic [PW-1:0] acc_reg;
  logic mclk_reg, fs_reg, sdo_reg;
  logic [7:0] slot_reg;
  logic [31:0] tx_sh_reg;
  logic [15:0] rx_sh_reg;
  vpcm_word_t hold_tx_reg, hold_ctrl_reg, rx_word_reg;
  logic hold_ctrl_v_reg, have_req_reg;

  wire logic [PW-1:0] acc_next = acc_reg + MCLK_INC;
  wire logic rise = acc_next[PW-1] && !acc_reg[PW-1];
  wire logic fall = !acc_next[PW-1] && acc_reg[PW-1];
  wire logic [7:0] slot_next = slot_reg + 8'h01;
  wire logic frame_start = rise && (slot_next == 8'h00);
  wire logic new_req = req_l2_reg ^ req_l3_reg;
  wire logic rx_last = fall && (slot_reg == `VPCM_SAMPLE_LAST_SLOT);
  wire logic [31:0] frame_word = {hold_tx_reg, hold_ctrl_v_reg ? hold_ctrl_reg : 16'h0000};

  assign rx_word_lnk = rx_word_reg;

  // Reset leaves the link domain in step with its own clock
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lrst_s1_reg <= 1'b1;
      lrst_reg <= 1'b1;
    end else begin
      lrst_s1_reg <= 1'b0;
      lrst_reg <= lrst_s1_reg;
    end
  end

  always_ff @(posedge link_clk_i or posedge lrst_reg) begin
    if (lrst_reg) begin
      en_l1_reg <= 1'b0;
      en_l2_reg <= 1'b0;
      req_l1_reg <= 1'b0;
      req_l2_reg <= 1'b0;
      req_l3_reg <= 1'b0;
      sdi_s1_reg <= 1'b0;
      sdi_s2_reg <= 1'b0;
    end else begin
      en_l1_reg <= en_sys_reg;
      en_l2_reg <= en_l1_reg;
      req_l1_reg <= req_tgl_reg;
      req_l2_reg <= req_l1_reg;
      req_l3_reg <= req_l2_reg;
      sdi_s1_reg <= serial_in_line_i;
      sdi_s2_reg <= sdi_s1_reg;
    end
  end

  // Master clock from a phase accumulator; jitter is one link period
  always_ff @(posedge link_clk_i or posedge lrst_reg) begin
    if (lrst_reg) begin
      acc_reg <= '0;
      mclk_reg <= 1'b0;
      slot_reg <= 8'hFF;
      fs_reg <= 1'b0;
    end else if (!en_l2_reg) begin
      acc_reg <= '0;
      mclk_reg <= 1'b0;
      slot_reg <= 8'hFF;
      fs_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      mclk_reg <= acc_next[PW-1];
      if (rise) begin
        slot_reg <= slot_next;
        fs_reg <= (slot_next == 8'h00);
      end
    end
  end

  always_ff @(posedge link_clk_i or posedge lrst_reg) begin
    if (lrst_reg) begin
      hold_tx_reg <= 16'h0000;
      hold_ctrl_reg <= 16'h0000;
      hold_ctrl_v_reg <= 1'b0;
      have_req_reg <= 1'b0;
      ack_tgl_lnk <= 1'b0;
    end else if (new_req) begin
      hold_tx_reg <= req_tx_reg;
      hold_ctrl_reg <= req_ctrl_reg;
      hold_ctrl_v_reg <= req_ctrl_v_reg;
      have_req_reg <= 1'b1;
    end else if (frame_start && have_req_reg) begin
      hold_ctrl_v_reg <= 1'b0;
      have_req_reg <= 1'b0;
      ack_tgl_lnk <= ~ack_tgl_lnk;
    end
  end

  always_ff @(posedge link_clk_i or posedge lrst_reg) begin
    if (lrst_reg) begin
      tx_sh_reg <= 32'h0000_0000;
      sdo_reg <= 1'b0;
    end else if (!en_l2_reg) begin
      tx_sh_reg <= 32'h0000_0000;
      sdo_reg <= 1'b0;
    end else if (frame_start) begin
      tx_sh_reg <= {frame_word[30:0], 1'b0};
      sdo_reg <= frame_word[31];
    end else if (rise) begin
      tx_sh_reg <= {tx_sh_reg[30:0], 1'b0};
      sdo_reg <= (slot_next <= `VPCM_CTRL_LAST_SLOT) ? tx_sh_reg[31] : 1'b0;
    end
  end

  always_ff @(posedge link_clk_i or posedge lrst_reg) begin
    if (lrst_reg) begin
      rx_sh_reg <= 16'h0000;
      rx_word_reg <= 16'h0000;
      rx_tgl_lnk <= 1'b0;
    end else if (en_l2_reg && fall && (slot_reg <= `VPCM_SAMPLE_LAST_SLOT)) begin
      rx_sh_reg <= {rx_sh_reg[14:0], sdi_s2_reg};
      if (rx_last) begin
        rx_word_reg <= {rx_sh_reg[14:0], sdi_s2_reg};
        rx_tgl_lnk <= ~rx_tgl_lnk;
      end
    end
  end

  assign clock_output_o = mclk_reg;
  assign frame_sync_o = fs_reg;
  assign serial_out_line_o = sdo_reg;
endmodule

// File: tb/vpcm_port_chk.sv
`timescale 1ns/1ps
module vpcm_port_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic mem_wr_i,
  input wire logic mem_rd_i,
  input wire vpcm_pkg::vpcm_word_t mem_addr_i,
  input wire vpcm_pkg::vpcm_word_t mem_wdata_i,
  input wire vpcm_pkg::vpcm_word_t mem_rdata_o,
  input wire logic route_wr_i,
  input wire vpcm_pkg::vpcm_word_t route_wdata_i,
  input wire vpcm_pkg::vpcm_word_t route_o,
  input wire logic tone_req_i,
  input wire logic tone_busy_o,
  input wire logic ctrl_pending_o,
  input wire logic clock_output_o,
  input wire logic frame_sync_o,
  input wire logic serial_out_line_o
);
  import vpcm_pkg::*;
  logic en_q;
  logic [3:0] off_q;
  logic [8:0] mc_q;
  logic [13:0] lk_q;
  logic [5:0] pc_q;
  logic fs_seen;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      off_q <= 4'h0;
    end else begin
      if (mem_wr_i && mem_addr_i == 16'h0059) en_q <= mem_wdata_i[0];
      off_q <= en_q ? 4'h0 : off_q + {3'h0, off_q != 4'hF};
    end
  end
  // lk_q and pc_q saturate so a long idle spell never yields a false frame length or master clock period
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mc_q <= 9'h000;
      lk_q <= 14'h0000;
      pc_q <= 6'h3F;
      fs_seen <= 1'b0;
    end else begin
      pc_q <= $rose(clock_output_o) ? 6'h01 : pc_q + {5'h00, pc_q != 6'h3F};
      if ($rose(frame_sync_o)) begin
        mc_q <= 9'h001;
        lk_q <= 14'h0001;
        fs_seen <= 1'b1;
      end else begin
        mc_q <= mc_q + {8'h00, $rose(clock_output_o)};
        lk_q <= lk_q + {13'h0000, lk_q != 14'h3FFF};
        fs_seen <= fs_seen && lk_q != 14'h3FFF;
      end
    end
  end
  AST_RDATA: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_rd_i && mem_addr_i == 16'h0059 |=> mem_rdata_o[0] == $past(en_q)) else $error("enable bit read wrong");
  AST_RZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    !(mem_rd_i && mem_addr_i == 16'h0059) |=> mem_rdata_o == 16'h0000) else $error("read data not zero");
  AST_PEND: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_wr_i && mem_addr_i == 16'h004B |=> ctrl_pending_o) else $error("control word not pending");
  AST_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
    route_wr_i |=> route_o == $past(route_wdata_i)) else $error("routing value not taken");
  AST_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    off_q == 4'hF |-> !clock_output_o && !frame_sync_o && !serial_out_line_o) else $error("link active while off");
  AST_TONE: assert property (@(posedge clk_i) disable iff (rst_i)
    tone_req_i && en_q && route_o == 16'h0011 && !tone_busy_o |=> tone_busy_o) else $error("tone not started");
  AST_FRAME: assert property (@(posedge link_clk_i) disable iff (rst_i)
    $rose(frame_sync_o) && fs_seen |-> mc_q == 9'h100) else $error("frame length wrong");
  AST_RATE: assert property (@(posedge link_clk_i) disable iff (rst_i)
    $rose(frame_sync_o) && fs_seen |-> lk_q inside {[14'h28AA:14'h28B8]}) else $error("frame rate wrong");
  AST_MCLK: assert property (@(posedge link_clk_i) disable iff (rst_i)
    $rose(clock_output_o) && pc_q != 6'h3F |-> pc_q inside {[6'h28:6'h2A]}) else $error("master clock rate wrong");
  cover property (@(posedge clk_i) $rose(tone_busy_o));
  cover property (@(posedge clk_i) $rose(ctrl_pending_o));
  cover property (@(posedge link_clk_i) $rose(frame_sync_o) && fs_seen);
endmodule
bind vpcm_port vpcm_port_chk i_chk (.clk_i, .rst_i, .link_clk_i, .mem_wr_i, .mem_rd_i, .mem_addr_i, .mem_wdata_i,
  .mem_rdata_o, .route_wr_i, .route_wdata_i, .route_o, .tone_req_i, .tone_busy_o, .ctrl_pending_o,
  .clock_output_o, .frame_sync_o, .serial_out_line_o);

// File: tb/vpcm_codec_model.sv
`timescale 1ns/1ps
module vpcm_codec_model (
  input wire logic mclk_i,
  input wire logic fs_i,
  input wire logic sdo_i,
  input wire logic [15:0] tx_i,
  output logic sdi_o,
  output logic [15:0] rx_o,
  output logic [15:0] ctl_o,
  output int nfr_o,
  output int nctl_o
);
  logic [7:0] slot = 8'hF0;
  logic [15:0] sh = 16'h0000;
  logic [15:0] rx_q = 16'h0000;
  logic [15:0] ctl_q = 16'h0000;
  logic sdi_q = 1'b0;
  int nfr_q = 0;
  int nctl_q = 0;
  assign sdi_o = sdi_q;
  assign rx_o = rx_q;
  assign ctl_o = ctl_q;
  assign nfr_o = nfr_q;
  assign nctl_o = nctl_q;
  // Frame sync is read on the fall, where it is settled
  always @(negedge mclk_i) begin
    slot = fs_i ? 8'h00 : slot + 8'h01;
    sh = {sh[14:0], sdo_i};
    if (slot == 8'h0F) begin
      rx_q = sh;
      nfr_q++;
    end
    if (slot == 8'h1F && sh != 16'h0000) begin
      ctl_q = sh;
      nctl_q++;
    end
  end
  // Pull-down on this line: low outside the sample slots
  always @(posedge mclk_i) begin
    sdi_q <= (slot == 8'hFF || slot < 8'h0F) ? tx_i[4'hE - slot[3:0]] : 1'b0;
  end
endmodule

// File: tb/tb_vpcm_port.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_vpcm_port;
  import vpcm_pkg::*;
  localparam int TS = 2;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic link_clk_i = 1'b0;
  logic mem_wr = 1'b0, mem_rd = 1'b0, route_wr = 1'b0, tone_req = 1'b0, line_valid = 1'b0;
  vpcm_word_t mem_addr = '0, mem_wdata = '0, route_wdata = '0, line_sample = '0, tx_w = '0;
  vpcm_word_t rdata, route, line_out, rx_w, ctl_w, lsamp;
  vpcm_digit_t digit = '0;
  logic busy, lv_o, pend, mclk, fs, serial_out_line, serial_in_line;
  int nfr, nctl, nlv = 0, ntone = 0, mismatches = 0, n_tests = 0;
  logic [31:0] seed = 32'h00001B64;
  initial forever #10 clk_i = ~clk_i;
  initial begin
    #3;
    forever #6 link_clk_i = ~link_clk_i;
  end
  vpcm_port #(.LINK_CLK_HZ(83333333), .TONE_SAMPLES(TS)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .link_clk_i(link_clk_i), .mem_wr_i(mem_wr), .mem_rd_i(mem_rd), .mem_addr_i(mem_addr),
    .mem_wdata_i(mem_wdata), .mem_rdata_o(rdata), .route_wr_i(route_wr), .route_wdata_i(route_wdata),
    .route_o(route), .tone_req_i(tone_req), .tone_digit_i(digit), .tone_busy_o(busy),
    .line_valid_i(line_valid), .line_sample_i(line_sample), .line_valid_o(lv_o), .line_sample_o(line_out),
    .ctrl_pending_o(pend), .clock_output_o(mclk), .frame_sync_o(fs), .serial_out_line_o(serial_out_line),
    .serial_in_line_i(serial_in_line));
  vpcm_codec_model i_codec (.mclk_i(mclk), .fs_i(fs), .sdo_i(serial_out_line), .tx_i(tx_w), .sdi_o(serial_in_line), .rx_o(rx_w),
    .ctl_o(ctl_w), .nfr_o(nfr), .nctl_o(nctl));
  always @(posedge clk_i) begin
    if (lv_o === 1'b1) begin
      nlv++;
      lsamp = line_out;
      // Only tone output differs from the codec word while busy
      if (busy === 1'b1 && line_out !== tx_w) ntone++;
    end
  end
  function automatic vpcm_word_t rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  // The host sets bit 0 here, keeping the rest of the word
  function automatic vpcm_word_t rmw(input vpcm_word_t v);
    return v | 16'h0001;
  endfunction
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input vpcm_word_t a, input vpcm_word_t d);
    @(posedge clk_i);
    mem_wr <= 1'b1;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge clk_i);
    mem_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input vpcm_word_t a, output vpcm_word_t d);
    @(posedge clk_i);
    mem_rd <= 1'b1;
    mem_addr <= a;
    @(posedge clk_i);
    mem_rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic frames(input int n);
    int f0;
    int k;
    f0 = nfr;
    k = 0;
    while (nfr < f0 + n && k < 7000 * n) begin
      @(posedge clk_i);
      k++;
    end
    if (nfr < f0 + n) begin
      mismatches++;
      test_done();
    end
    repeat (20) @(posedge clk_i);
  endtask
  initial begin
    vpcm_word_t v;
    vpcm_word_t w;
    int k;
    int f0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(16'h0059, v);
    `CHK("enable reset", 16'h0000, v)
    `CHK("route reset", 16'h0000, route)
    w = rnd();
    wr(16'h0060 + {8'h00, w[7:0]}, w);
    rd(16'h004B, v);
    `CHK("control read", 16'h0000, v)
    wr(16'h0059, w & 16'hFFFE);
    repeat (200) @(posedge clk_i);
    `CHK("frames while off", 0, nfr)
    rd(16'h0059, v);
    `CHK("enable word", w & 16'hFFFE, v)
    wr(16'h0059, rmw(v));
    rd(16'h0059, v);
    `CHK("enable set", rmw(w & 16'hFFFE), v)
    k = nlv;
    frames(1);
    `CHK("unrouted samples", k, nlv)
    @(posedge clk_i);
    route_wr <= 1'b1;
    route_wdata <= 16'h0011;
    @(posedge clk_i);
    route_wr <= 1'b0;
    #1 `CHK("route", 16'h0011, route)
    for (k = 0; k < 2; k++) begin
      @(posedge clk_i);
      w = k ? rnd() : 16'h8001;
      tx_w <= k ? rnd() : 16'h7FFE;
      line_valid <= 1'b1;
      line_sample <= w;
      @(posedge clk_i);
      line_valid <= 1'b0;
      frames(2);
      `CHK("to codec", w, rx_w)
      `CHK("to line", tx_w, lsamp)
    end
    for (k = 0; k < 2; k++) begin
      f0 = nctl;
      w = k ? 16'h0545 : 16'h011C;
      wr(16'h004B, w);
      `CHK("pending", 1'b1, pend)
      // The word rides the frame after the next hand-off, in its later slots
      frames(3);
      `CHK("control word", w, ctl_w)
      `CHK("control count", f0 + 1, nctl)
      `CHK("pending clear", 1'b0, pend)
    end
    @(posedge clk_i);
    tone_req <= 1'b1;
    w = rnd();
    digit <= w[3:0];
    @(posedge clk_i);
    tone_req <= 1'b0;
    #1 `CHK("tone busy", 1'b1, busy)
    f0 = nfr;
    @(posedge clk_i);
    tone_req <= 1'b1;
    digit <= 4'hF;
    @(posedge clk_i);
    tone_req <= 1'b0;
    k = 0;
    while (busy === 1'b1 && k < 25000) begin
      @(posedge clk_i);
      k++;
    end
    if (busy === 1'b1) begin
      mismatches++;
      test_done();
    end
    `CHK("tone length", 1'b1, (nfr - f0 >= TS && nfr - f0 <= TS + 1))
    `CHK("tone samples", TS, ntone)
    frames(2);
    `CHK("voice resumed", tx_w, lsamp)
    test_done();
  end
endmodule
